// ==== rtl/pcr_pkg.sv ====
// Constants for the port charge and removable configuration bank
package pcr_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [7:0] BATTERY_CHARGE_SUPPORT_OFS = 8'h06;
  localparam logic [7:0] DEVICE_REMOVABLE_CONFIG_OFS = 8'h07;
  localparam int unsigned OVERRIDE_BIT = 7;
  localparam int unsigned PORT_FIELD_LSB = 0;
  localparam logic [3:0] CHARGE_ENABLE_RESET = 4'h0;
  localparam logic [3:0] REMOVABLE_RESET = 4'h0;
  localparam logic OVERRIDE_RESET = 1'b0;
  localparam int unsigned STRAP_SYNC_STAGES = 2;
endpackage

// ==== rtl/pcr_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pcr_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ==== rtl/pcr_cfg_regs.sv ====
// Battery charge support and device removable configuration registers
//
// Summary of operation
// - Bit 7 of the removable register is the override that governs write access to the per-port removable bits.
// - With override 0 the removable field is read-only and comes from OTP.
// - With override 1 that field is writable by register writes.
// - One write may set the override and the removable bits together, both taking effect at once.
// - Bits 6 to 4 of the removable register read zero and ignore writes.
// - Removable bit 1 reports a removable device, 0 a permanently attached one.
// - Removable bit n describes downstream port n+1.
// - Writes to the removable field are ignored unless the same write sets override (bit 7) to 1.
// - While not writable the removable field shows the inverse of the OTP non-removable field.
`timescale 1ns/1ps
module pcr_cfg_regs #(
  parameter int NUM_PORTS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [NUM_PORTS-1:0] charge_strap_pins,
  input wire logic [NUM_PORTS-1:0] otp_non_removable,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [NUM_PORTS-1:0] charge_port_enable,
  output logic [NUM_PORTS-1:0] port_removable,
  output logic removable_override
);
  typedef enum logic [1:0] {
    PCR_FILL = 2'b00,
    PCR_RUN = 2'b01
  } pcr_strap_state_t;

  logic [NUM_PORTS-1:0] strap_sync;
  pcr_strap_state_t strap_state_ff;
  pcr_strap_state_t nxt_strap_state;
  logic [1:0] fill_cnt_ff;
  logic [1:0] nxt_fill_cnt;
  logic strap_load;
  logic [NUM_PORTS-1:0] charge_ff;
  logic [NUM_PORTS-1:0] nxt_charge;
  logic override_ff;
  logic nxt_override;
  logic [NUM_PORTS-1:0] removable_ff;
  logic [NUM_PORTS-1:0] nxt_removable;
  logic [NUM_PORTS-1:0] view_ff;
  wire [NUM_PORTS-1:0] nxt_view;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic wr_charge;
  logic wr_removable;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Unmapped offsets and unused upper bits read as zero
  function automatic logic [7:0] read_word(
    input logic [7:0] addr,
    input logic [NUM_PORTS-1:0] charge,
    input logic override,
    input logic [NUM_PORTS-1:0] view
  );
    read_word = 8'h00;
    if (addr_hit(addr, pcr_pkg::BATTERY_CHARGE_SUPPORT_OFS)) begin
      read_word[NUM_PORTS-1:0] = charge;
    end else if (addr_hit(addr, pcr_pkg::DEVICE_REMOVABLE_CONFIG_OFS)) begin
      read_word[pcr_pkg::OVERRIDE_BIT] = override;
      read_word[NUM_PORTS-1:0] = view;
    end
  endfunction

  pcr_sync #(
    .WIDTH(NUM_PORTS)
  ) u_strap_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(charge_strap_pins),
    .sync_out(strap_sync)
  );

  assign wr_charge = reg_wr_en && addr_hit(reg_addr, pcr_pkg::BATTERY_CHARGE_SUPPORT_OFS);
  assign wr_removable = reg_wr_en && addr_hit(reg_addr, pcr_pkg::DEVICE_REMOVABLE_CONFIG_OFS);

  // Strap is caught once the synchroniser has filled after reset release
  always_comb begin
    nxt_strap_state = strap_state_ff;
    nxt_fill_cnt = fill_cnt_ff;
    strap_load = 1'b0;
    case (strap_state_ff)
      PCR_FILL: begin
        if (fill_cnt_ff == 2'(pcr_pkg::STRAP_SYNC_STAGES)) begin
          strap_load = 1'b1;
          nxt_strap_state = PCR_RUN;
        end else begin
          nxt_fill_cnt = fill_cnt_ff + 2'h1;
        end
      end
      PCR_RUN: begin
        nxt_strap_state = PCR_RUN;
      end
      default: begin
        nxt_strap_state = PCR_FILL;
        nxt_fill_cnt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_state_ff <= PCR_FILL;
    end else begin
      strap_state_ff <= nxt_strap_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fill_cnt_ff <= 2'h0;
    end else begin
      fill_cnt_ff <= nxt_fill_cnt;
    end
  end

  // Strap load wins over an early host write; the host must wait for it
  always_comb begin
    nxt_charge = charge_ff;
    if (strap_load) begin
      nxt_charge = strap_sync;
    end else if (wr_charge) begin
      nxt_charge = reg_wdata[NUM_PORTS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      charge_ff <= pcr_pkg::CHARGE_ENABLE_RESET;
    end else begin
      charge_ff <= nxt_charge;
    end
  end

  always_comb begin
    nxt_override = override_ff;
    if (wr_removable) begin
      nxt_override = reg_wdata[pcr_pkg::OVERRIDE_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      override_ff <= pcr_pkg::OVERRIDE_RESET;
    end else begin
      override_ff <= nxt_override;
    end
  end

  // A write that sets override also takes the removable bits, whatever the old override
  always_comb begin
    nxt_removable = removable_ff;
    if (wr_removable && reg_wdata[pcr_pkg::OVERRIDE_BIT]) begin
      nxt_removable = reg_wdata[NUM_PORTS-1:0];
    end
  end

  // Stored bits survive a freeze, but the write that lifts override again replaces them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      removable_ff <= pcr_pkg::REMOVABLE_RESET;
    end else begin
      removable_ff <= nxt_removable;
    end
  end

  // View built from next values so override and bits land on one edge
  genvar port_idx;
  generate
    for (port_idx = 0; port_idx < NUM_PORTS; port_idx++) begin : g_port
      assign nxt_view[port_idx] = nxt_override ? nxt_removable[port_idx] :
        ~otp_non_removable[port_idx];
    end
  endgenerate

  // OTP changes show one cycle late; the field is static in use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      view_ff <= pcr_pkg::REMOVABLE_RESET;
    end else begin
      view_ff <= nxt_view;
    end
  end

  always_comb begin
    nxt_rdata = read_word(reg_addr, charge_ff, override_ff, view_ff);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign port_removable = view_ff;
  assign charge_port_enable = charge_ff;
  assign removable_override = override_ff;
  assign reg_rdata = rdata_ff;
endmodule

// ==== verif/pcr_cfg_regs_sva.sv ====
// Port checks for the config bank
`timescale 1ns/1ps
module pcr_cfg_regs_sva #(parameter int NUM_PORTS = 4) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic removable_override,
  input wire logic [NUM_PORTS-1:0] charge_strap_pins,
  input wire logic [NUM_PORTS-1:0] otp_non_removable,
  input wire logic [NUM_PORTS-1:0] charge_port_enable,
  input wire logic [NUM_PORTS-1:0] port_removable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire w7 = reg_wr_en && reg_addr == 8'h07;
  ovr_wr_a: assert property (w7 |=> removable_override == $past(reg_wdata[7])) else $error("ovr");
  rmb_ld_a: assert property (w7 && reg_wdata[7] |=> port_removable == $past(reg_wdata[3:0]))
    else $error("ld");
  rmb_frz_a: assert property (!removable_override && $past(rst_n) |->
    port_removable == ~$past(otp_non_removable)) else $error("frz");
  rmb_ign_a: assert property (w7 && !reg_wdata[7] |=>
    port_removable == ~$past(otp_non_removable)) else $error("ign");
  rd_rmb_a: assert property (reg_addr == 8'h07 && !reg_wr_en |=>
    reg_rdata == $past({removable_override, 3'h0, port_removable})) else $error("rd7");
  rd_chg_a: assert property (reg_addr == 8'h06 && !reg_wr_en |=>
    reg_rdata == $past({4'h0, charge_port_enable})) else $error("rd6");
  chg_wr_a: assert property (reg_wr_en && reg_addr == 8'h06 && $past(rst_n, 3) |=>
    charge_port_enable == $past(reg_wdata[3:0])) else $error("wr6");
  strap_ld_a: assert property ($past(rst_n, 3) && !$past(rst_n, 4) |->
    charge_port_enable == $past(charge_strap_pins, 3)) else $error("strap");
endmodule
bind pcr_cfg_regs pcr_cfg_regs_sva #(.NUM_PORTS(NUM_PORTS)) i_sva (.*);

// ==== verif/pcr_host.sv ====
// Register host model
`timescale 1ns/1ps
module pcr_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr_en,
  output logic [7:0] reg_addr, reg_wdata
);
  initial {reg_wr_en, reg_addr, reg_wdata} = 17'h0;
  task wr(input logic [7:0] a, d);
    @(posedge mclk) #1 {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
    // Released data flips so stale data cannot pass
    @(posedge mclk) #1 {reg_wr_en, reg_wdata} = {1'b0, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk) #1 reg_addr = a;
    @(posedge mclk) #1 q = reg_rdata;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Bench for the config bank
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr_en, removable_override;
  logic [3:0] charge_strap_pins = 4'ha, otp_non_removable = 4'h3, charge_port_enable, port_removable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int fails = 0, comparisons = 0;
  always #2.5 mclk = ~mclk;
  pcr_cfg_regs i_pcr_cfg_regs (.*);
  pcr_host i_pcr_host (.*);
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input bit w, input logic [7:0] a, d, e);
    logic [7:0] q;
    if (w) i_pcr_host.wr(a, d);
    i_pcr_host.rd(a, q);
    chk(q, e);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000 fails++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    acc(0, 8'h06, 8'h0, 8'h0a);
    acc(1, 8'h06, 8'hff, 8'h0f);
    chk({4'h0, charge_port_enable}, 8'h0f);
    acc(1, 8'h07, 8'h75, 8'h0c);
    chk({4'h0, port_removable}, 8'h0c);
    acc(1, 8'h07, 8'hf5, 8'h85);
    chk({4'h0, port_removable}, 8'h05);
    chk({7'h0, removable_override}, 8'h01);
    acc(1, 8'h07, 8'h8a, 8'h8a);
    acc(1, 8'h07, 8'h0f, 8'h0c);
    acc(0, 8'h09, 8'h0, 8'h00);
    print_verdict();
  end
endmodule
